//--- peripheral_clock_gating_bank1.sv
// Clock gating control for timers, quadrature, sync and async serial units, with an AXI4-Lite slave.
//
// Functional notes
// - a unit is clocked exactly when its gate bit is set for the active mode.
// - any access to a unit whose clock is off answers with a bus fault.
// - all gating registers reset to zero; implemented gate bits are read-write.
// - run register while running, sleep register in sleep, deep register in deep sleep.
// - sleep and deep registers apply only with auto gating select set, else run register.
// - bits 19, 18, 17, 16 gate counters c3, c2, c1, c0.
// - bit 8 gates the quadrature encoder unit.
// - bit 4 gates the synchronous serial unit.
// - bit 0 gates the asynchronous serial unit.
// - bits 31:20, 15:9, 7:5, 3:1 read zero; software preserves them.
// - deep-sleep gating register sits at offset 0x124.
// - run-mode gating register sits at offset 0x104.
// - sleep-mode gating register sits at offset 0x114.
//
// Chosen here: the AXI4-Lite slave port.
`include "clock_gate_defines.svh"

module peripheral_clock_gating_bank1 (
	// Clock and reset
	input  wire logic        SYS_CLK,
	input  wire logic        RESET_N,
	// AXI4-Lite write address and data
	input  wire logic [31:0] AXI_AWADDR,
	input  wire logic [2:0]  AXI_AWPROT,
	input  wire logic        AXI_AWVALID,
	output logic             AXI_AWREADY,
	input  wire logic [31:0] AXI_WDATA,
	input  wire logic [3:0]  AXI_WSTRB,
	input  wire logic        AXI_WVALID,
	output logic             AXI_WREADY,
	// AXI4-Lite write response
	output logic [1:0]       AXI_BRESP,
	output logic             AXI_BVALID,
	input  wire logic        AXI_BREADY,
	// AXI4-Lite read
	input  wire logic [31:0] AXI_ARADDR,
	input  wire logic [2:0]  AXI_ARPROT,
	input  wire logic        AXI_ARVALID,
	output logic             AXI_ARREADY,
	output logic [31:0]      AXI_RDATA,
	output logic [1:0]       AXI_RRESP,
	output logic             AXI_RVALID,
	input  wire logic        AXI_RREADY,
	// Power mode from the system
	input  wire logic [1:0]  POWER_MODE,
	// Peripheral access check
	input  wire logic [6:0]  UNIT_SEL,
	output logic [6:0]       UNIT_BUS_FAULT,
	// Unit clocks
	output logic [6:0]       UNIT_CLK_EN,
	output logic [6:0]       UNIT_CLK,
	// Interrupt
	output logic             IRQ
);

	// ****************************************************************
	// Unit map and state
	// ****************************************************************
	localparam int UNIT_BIT [7] = '{
		`CG_BIT_ASYNC_SERIAL,
		`CG_BIT_SYNC_SERIAL,
		`CG_BIT_QUADRATURE,
		`CG_BIT_COUNTER_C0,
		`CG_BIT_COUNTER_C1,
		`CG_BIT_COUNTER_C2,
		`CG_BIT_COUNTER_C3
	};

	clock_gate_pkg::gate_state_t q;
	clock_gate_pkg::gate_state_t d;
	logic [6:0]                  run_vec;
	logic [6:0]                  sleep_vec;
	logic [6:0]                  deep_vec;
	logic [6:0]                  sel_vec;
	logic                        wr_fire;
	logic                        ev_fault;
	logic                        ev_mode;
	clock_gate_pkg::power_mode_t mode_in;

	function automatic logic [31:0] merge_bytes(input logic [31:0] old_v, input logic [31:0] new_v,
		input logic [3:0] strb);
		logic [31:0] r;
		r = old_v;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				r[8*b +: 8] = new_v[8*b +: 8];
			end
		end
		return r;
	endfunction

	// ****************************************************************
	// Per-unit gate bit selection and clock gates
	// ****************************************************************
	for (genvar i = 0; i < 7; i++) begin : g_unit
		assign run_vec[i]   = q.run_gate[UNIT_BIT[i]];
		assign sleep_vec[i] = q.sleep_gate[UNIT_BIT[i]];
		assign deep_vec[i]  = q.deep_gate[UNIT_BIT[i]];

		// Each unit clock passes through its own latch gate.
		clock_gate_cell u_gate (
			.clk       (SYS_CLK),
			.rst_n     (RESET_N),
			.enable    (q.unit_en[i]),
			.gated_clk (UNIT_CLK[i])
		);
	end

	// ****************************************************************
	// Next state
	// ****************************************************************
	always_comb begin
		logic [31:0] merged;
		logic [1:0]  irq_clr;
		logic [1:0]  irq_set;
		merged  = 32'h00000000;
		irq_clr = 2'h0;
		irq_set = 2'h0;
		d       = q;
		mode_in = clock_gate_pkg::PM_RUN;

		// Write address and data are taken in either order.
		if (AXI_AWVALID && !q.aw_got) begin
			d.aw_got  = 1'b1;
			d.aw_addr = AXI_AWADDR[11:0];
		end
		if (AXI_WVALID && !q.w_got) begin
			d.w_got  = 1'b1;
			d.w_data = AXI_WDATA;
			d.w_strb = AXI_WSTRB;
		end
		if (q.bvalid && AXI_BREADY) begin
			d.bvalid = 1'b0;
		end

		wr_fire = q.aw_got && q.w_got && !q.bvalid;
		if (wr_fire) begin
			d.aw_got = 1'b0;
			d.w_got  = 1'b0;
			d.bvalid = 1'b1;
			d.bresp  = `CG_RESP_OKAY;
			unique case (q.aw_addr)
				`CG_OFS_RUN_GATE: begin
					merged     = merge_bytes(q.run_gate, q.w_data, q.w_strb);
					d.run_gate = merged & `CG_GATE_IMPL_MASK;
				end
				`CG_OFS_SLEEP_GATE: begin
					merged       = merge_bytes(q.sleep_gate, q.w_data, q.w_strb);
					d.sleep_gate = merged & `CG_GATE_IMPL_MASK;
				end
				`CG_OFS_DEEP_GATE: begin
					merged      = merge_bytes(q.deep_gate, q.w_data, q.w_strb);
					d.deep_gate = merged & `CG_GATE_IMPL_MASK;
				end
				`CG_OFS_RUN_CONFIG: begin
					merged               = merge_bytes({4'h0, q.auto_gating_select, 27'h0}, q.w_data, q.w_strb);
					d.auto_gating_select = merged[`CG_BIT_AUTO_GATING];
				end
				`CG_OFS_IRQ_STATUS: begin
					if (q.w_strb[0]) begin
						irq_clr = q.w_data[1:0];
					end
				end
				`CG_OFS_IRQ_MASK: begin
					if (q.w_strb[0]) begin
						d.irq_mask = q.w_data[1:0];
					end
				end
				`CG_OFS_ACTIVE_GATE: begin
					d.bresp = `CG_RESP_OKAY;
				end
				default: begin
					d.bresp = `CG_RESP_SLVERR;
				end
			endcase
		end

		// Reads answer one cycle after the address is taken.
		if (q.rvalid && AXI_RREADY) begin
			d.rvalid = 1'b0;
		end
		if (AXI_ARVALID && !q.rvalid) begin
			d.rvalid = 1'b1;
			d.rresp  = `CG_RESP_OKAY;
			unique case (AXI_ARADDR[11:0])
				`CG_OFS_RUN_GATE:    d.rdata = q.run_gate;
				`CG_OFS_SLEEP_GATE:  d.rdata = q.sleep_gate;
				`CG_OFS_DEEP_GATE:   d.rdata = q.deep_gate;
				`CG_OFS_RUN_CONFIG:  d.rdata = {4'h0, q.auto_gating_select, 27'h0};
				`CG_OFS_IRQ_STATUS:  d.rdata = {30'h0, q.irq_status};
				`CG_OFS_IRQ_MASK:    d.rdata = {30'h0, q.irq_mask};
				`CG_OFS_ACTIVE_GATE: begin
					d.rdata = 32'h00000000;
					for (int u = 0; u < 7; u++) begin
						d.rdata[UNIT_BIT[u]] = q.unit_en[u];
					end
				end
				default: begin
					d.rdata = 32'h00000000;
					d.rresp = `CG_RESP_SLVERR;
				end
			endcase
		end

		// Gate bits come from the register of the active power mode with auto gating select set, else from the run register.
		unique case (POWER_MODE)
			2'h1:    mode_in = clock_gate_pkg::PM_SLEEP;
			2'h2:    mode_in = clock_gate_pkg::PM_DEEP;
			default: mode_in = clock_gate_pkg::PM_RUN;
		endcase
		unique case (mode_in)
			clock_gate_pkg::PM_SLEEP: sel_vec = q.auto_gating_select ? sleep_vec : run_vec;
			clock_gate_pkg::PM_DEEP:  sel_vec = q.auto_gating_select ? deep_vec : run_vec;
			default:                  sel_vec = run_vec;
		endcase
		d.unit_en = sel_vec;
		d.mode    = mode_in;

		// Events; a new event beats a clear written in the same cycle.
		ev_fault = |(UNIT_SEL & ~q.unit_en);
		ev_mode  = mode_in != q.mode;
		irq_set[`CG_IRQ_BIT_FAULT] = ev_fault;
		irq_set[`CG_IRQ_BIT_MODE]  = ev_mode;
		d.irq_status = (q.irq_status & ~irq_clr) | irq_set;
	end

	// ****************************************************************
	// State register
	// ****************************************************************
	always_ff @(posedge SYS_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			q                    <= '0;
			q.run_gate           <= `CG_GATE_RESET;
			q.sleep_gate         <= `CG_GATE_RESET;
			q.deep_gate          <= `CG_GATE_RESET;
			q.irq_status         <= `CG_IRQ_RESET;
			q.irq_mask           <= `CG_IRQ_RESET;
			q.mode               <= clock_gate_pkg::PM_RUN;
		end else begin
			q <= d;
		end
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************
	assign AXI_AWREADY    = !q.aw_got;
	assign AXI_WREADY     = !q.w_got;
	assign AXI_BVALID     = q.bvalid;
	assign AXI_BRESP      = q.bresp;
	assign AXI_ARREADY    = !q.rvalid;
	assign AXI_RVALID     = q.rvalid;
	assign AXI_RDATA      = q.rdata;
	assign AXI_RRESP      = q.rresp;
	assign UNIT_CLK_EN    = q.unit_en;
	assign UNIT_BUS_FAULT = UNIT_SEL & ~q.unit_en;
	assign IRQ            = |(q.irq_status & q.irq_mask);

	// ****************************************************************
	// Assertions
	// ****************************************************************
	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (!RESET_N);

	property p_fault_on_gated;
		(UNIT_SEL[3] && !UNIT_CLK_EN[3]) |-> UNIT_BUS_FAULT[3] ##1 q.irq_status[`CG_IRQ_BIT_FAULT];
	endproperty
	a_fault_on_gated: assert property (p_fault_on_gated) else $error("gated unit access gave no fault");

	property p_no_fault_when_clocked;
		(UNIT_SEL != 7'h00 && (UNIT_SEL & ~UNIT_CLK_EN) == 7'h00) |-> UNIT_BUS_FAULT == 7'h00;
	endproperty
	a_no_fault_when_clocked: assert property (p_no_fault_when_clocked) else $error("fault on clocked unit");

	property p_reserved_zero;
		((q.run_gate | q.sleep_gate | q.deep_gate) & ~`CG_GATE_IMPL_MASK) == 32'h00000000;
	endproperty
	a_reserved_zero: assert property (p_reserved_zero) else $error("reserved gate bit set");

	property p_run_select;
		(POWER_MODE == 2'h0) |=> UNIT_CLK_EN == $past(run_vec);
	endproperty
	a_run_select: assert property (p_run_select) else $error("run mode used wrong gate bits");

	property p_sleep_select;
		(POWER_MODE == 2'h1 && q.auto_gating_select) |=> UNIT_CLK_EN == $past(sleep_vec);
	endproperty
	a_sleep_select: assert property (p_sleep_select) else $error("sleep mode used wrong gate bits");

	property p_no_auto_gating;
		(POWER_MODE == 2'h2 && !q.auto_gating_select) |=> UNIT_CLK_EN == $past(run_vec);
	endproperty
	a_no_auto_gating: assert property (p_no_auto_gating) else $error("deep bits used without auto gating");

	property p_counter_c3_bit;
		(POWER_MODE == 2'h0) |=> UNIT_CLK_EN[6] == $past(q.run_gate[`CG_BIT_COUNTER_C3]);
	endproperty
	a_counter_c3_bit: assert property (p_counter_c3_bit) else $error("counter c3 not on bit 19");

	property p_quadrature_bit;
		(POWER_MODE == 2'h0) |=> UNIT_CLK_EN[2] == $past(q.run_gate[`CG_BIT_QUADRATURE]);
	endproperty
	a_quadrature_bit: assert property (p_quadrature_bit) else $error("quadrature not on bit 8");

	property p_sync_serial_bit;
		(POWER_MODE == 2'h0) |=> UNIT_CLK_EN[1] == $past(q.run_gate[`CG_BIT_SYNC_SERIAL]);
	endproperty
	a_sync_serial_bit: assert property (p_sync_serial_bit) else $error("sync serial not on bit 4");

	property p_async_serial_bit;
		(POWER_MODE == 2'h0) |=> UNIT_CLK_EN[0] == $past(q.run_gate[`CG_BIT_ASYNC_SERIAL]);
	endproperty
	a_async_serial_bit: assert property (p_async_serial_bit) else $error("async serial not on bit 0");

	property p_deep_decode;
		(wr_fire && q.aw_addr == `CG_OFS_DEEP_GATE && q.w_strb == 4'hF)
			|=> q.deep_gate == ($past(q.w_data) & `CG_GATE_IMPL_MASK) && AXI_BVALID;
	endproperty
	a_deep_decode: assert property (p_deep_decode) else $error("deep gate write not decoded");

	property p_run_decode;
		(wr_fire && q.aw_addr == `CG_OFS_RUN_GATE && q.w_strb == 4'hF)
			|=> q.run_gate == ($past(q.w_data) & `CG_GATE_IMPL_MASK);
	endproperty
	a_run_decode: assert property (p_run_decode) else $error("run gate write not decoded");

	property p_sleep_decode;
		(wr_fire && q.aw_addr == `CG_OFS_SLEEP_GATE && q.w_strb == 4'hF)
			|=> q.sleep_gate == ($past(q.w_data) & `CG_GATE_IMPL_MASK);
	endproperty
	a_sleep_decode: assert property (p_sleep_decode) else $error("sleep gate write not decoded");

	// The high phase of each gated clock is seen at the falling edge; it must follow the enable of the cycle before.
	property p_gate_clock_low;
		@(negedge SYS_CLK) UNIT_CLK == $past(UNIT_CLK_EN);
	endproperty
	a_gate_clock_low: assert property (p_gate_clock_low) else $error("gated clock does not follow its enable");

	property p_reset_zero;
		$rose(RESET_N) |-> q.run_gate == `CG_GATE_RESET;
	endproperty
	a_reset_zero: assert property (@(posedge SYS_CLK) p_reset_zero) else $error("run gate not zero after reset");

	c_fault:      cover property (UNIT_BUS_FAULT != 7'h00);
	c_sleep_gate: cover property (POWER_MODE == 2'h1 && q.auto_gating_select ##1 UNIT_CLK_EN != 7'h00);
	c_irq:        cover property ($rose(IRQ));
	c_deep_write: cover property (wr_fire && q.aw_addr == `CG_OFS_DEEP_GATE);

endmodule

//--- clock_gate_defines.svh
// Offsets, field positions, reset values and response codes of the peripheral clock gating bank.
`ifndef CLOCK_GATE_DEFINES_SVH
`define CLOCK_GATE_DEFINES_SVH

// ****************************************************************
// Register offsets (low twelve bits of the byte address)
// ****************************************************************
`define CG_OFS_RUN_CONFIG    12'h060
`define CG_OFS_RUN_GATE      12'h104
`define CG_OFS_SLEEP_GATE    12'h114
`define CG_OFS_DEEP_GATE     12'h124
`define CG_OFS_IRQ_STATUS    12'h200
`define CG_OFS_IRQ_MASK      12'h204
`define CG_OFS_ACTIVE_GATE   12'h208

// ****************************************************************
// Field positions and reset values
// ****************************************************************
`define CG_BIT_ASYNC_SERIAL  0
`define CG_BIT_SYNC_SERIAL   4
`define CG_BIT_QUADRATURE    8
`define CG_BIT_COUNTER_C0    16
`define CG_BIT_COUNTER_C1    17
`define CG_BIT_COUNTER_C2    18
`define CG_BIT_COUNTER_C3    19
`define CG_BIT_AUTO_GATING   27
`define CG_IRQ_BIT_FAULT     0
`define CG_IRQ_BIT_MODE      1
`define CG_GATE_IMPL_MASK    32'h000F0111
`define CG_GATE_RESET        32'h00000000
`define CG_IRQ_RESET         2'h0

// ****************************************************************
// Bus response codes
// ****************************************************************
`define CG_RESP_OKAY         2'h0
`define CG_RESP_SLVERR       2'h2

`endif

//--- clock_gate_pkg.sv
// Types shared by the peripheral clock gating bank.
package clock_gate_pkg;

	typedef enum logic [1:0] {
		PM_RUN,
		PM_SLEEP,
		PM_DEEP
	} power_mode_t;

	typedef struct packed {
		logic        aw_got;
		logic [11:0] aw_addr;
		logic        w_got;
		logic [31:0] w_data;
		logic [3:0]  w_strb;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        rvalid;
		logic [1:0]  rresp;
		logic [31:0] rdata;
		logic [31:0] run_gate;
		logic [31:0] sleep_gate;
		logic [31:0] deep_gate;
		logic        auto_gating_select;
		logic [1:0]  irq_status;
		logic [1:0]  irq_mask;
		power_mode_t mode;
		logic [6:0]  unit_en;
	} gate_state_t;

endpackage

//--- clock_gate_cell.sv
// Latch based glitch-free clock gate for one peripheral unit.
module clock_gate_cell (
	// Clock and reset
	input  wire logic clk,
	input  wire logic rst_n,
	// Enable and gated clock
	input  wire logic enable,
	output logic      gated_clk
);

	logic en_latched;

	// The enable only passes while the clock is low, so a change can never cut a high phase short.
	always_latch begin
		if (!rst_n) begin
			en_latched = 1'b0;
		end else if (!clk) begin
			en_latched = enable;
		end
	end

	assign gated_clk = clk & en_latched;

endmodule

//--- gated_unit_model.sv
// Model of one gated peripheral unit that counts the clock edges it receives.
module gated_unit_model (
	// Gated clock and count control
	input  wire logic unit_clk,
	input  wire logic clear,
	// Edges seen since the last clear
	output int        ticks
);
	timeunit 1ns;
	timeprecision 1ps;

	// A unit whose clock is gated off sees no edge, so its count stands still.
	always @(posedge unit_clk or posedge clear) begin
		if (clear) begin
			ticks <= 0;
		end else begin
			ticks <= ticks + 1;
		end
	end
endmodule

//--- peripheral_clock_gating_bank1_bench.sv
// Self-checking bench of the peripheral clock gating bank.
`include "clock_gate_defines.svh"
module peripheral_clock_gating_bank1_bench;
	timeunit 1ns;
	timeprecision 1ps;

	// ****************************************************************
	// Signals and instances
	// ****************************************************************
	logic        SYS_CLK, RESET_N, clr, IRQ;
	logic        AXI_AWVALID, AXI_AWREADY, AXI_WVALID, AXI_WREADY, AXI_BVALID, AXI_BREADY;
	logic        AXI_ARVALID, AXI_ARREADY, AXI_RVALID, AXI_RREADY;
	logic [31:0] AXI_AWADDR, AXI_WDATA, AXI_ARADDR, AXI_RDATA;
	logic [1:0]  AXI_BRESP, AXI_RRESP, POWER_MODE;
	logic [6:0]  UNIT_SEL, UNIT_BUS_FAULT, UNIT_CLK_EN, UNIT_CLK;
	logic [11:0] gate_ofs [3];
	logic [31:0] mode_gate [4];
	logic [6:0]  mode_en [4];
	int          bit_pos [7];
	int          ticks [7];
	int          n_mismatch, num_checks;

	peripheral_clock_gating_bank1 u_peripheral_clock_gating_bank1 (
		.SYS_CLK(SYS_CLK), .RESET_N(RESET_N),
		.AXI_AWADDR(AXI_AWADDR), .AXI_AWPROT(3'h0), .AXI_AWVALID(AXI_AWVALID), .AXI_AWREADY(AXI_AWREADY),
		.AXI_WDATA(AXI_WDATA), .AXI_WSTRB(4'hF), .AXI_WVALID(AXI_WVALID), .AXI_WREADY(AXI_WREADY),
		.AXI_BRESP(AXI_BRESP), .AXI_BVALID(AXI_BVALID), .AXI_BREADY(AXI_BREADY),
		.AXI_ARADDR(AXI_ARADDR), .AXI_ARPROT(3'h0), .AXI_ARVALID(AXI_ARVALID), .AXI_ARREADY(AXI_ARREADY),
		.AXI_RDATA(AXI_RDATA), .AXI_RRESP(AXI_RRESP), .AXI_RVALID(AXI_RVALID), .AXI_RREADY(AXI_RREADY),
		.POWER_MODE(POWER_MODE), .UNIT_SEL(UNIT_SEL), .UNIT_BUS_FAULT(UNIT_BUS_FAULT),
		.UNIT_CLK_EN(UNIT_CLK_EN), .UNIT_CLK(UNIT_CLK), .IRQ(IRQ)
	);

	for (genvar g = 0; g < 7; g++) begin : g_unit
		gated_unit_model u_gated_unit_model (.unit_clk(UNIT_CLK[g]), .clear(clr), .ticks(ticks[g]));
	end

	always #4 SYS_CLK = ~SYS_CLK;

	// ****************************************************************
	// Tasks
	// ****************************************************************
	task automatic end_sim();
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic hang(input string what);
		n_mismatch++;
		$display("CHECK FAILED %s expected answer seen timeout", what);
		end_sim();
	endtask

	task automatic axi_write(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
		int n;
		@(posedge SYS_CLK);
		n = 0;
		AXI_AWADDR  <= {20'h00000, a};
		AXI_WDATA   <= d;
		AXI_AWVALID <= 1'b1;
		AXI_WVALID  <= 1'b1;
		AXI_BREADY  <= 1'b1;
		do begin
			@(posedge SYS_CLK);
			n++;
			if (AXI_AWVALID === 1'b1 && AXI_AWREADY === 1'b1) AXI_AWVALID <= 1'b0;
			if (AXI_WVALID === 1'b1 && AXI_WREADY === 1'b1) AXI_WVALID <= 1'b0;
		end while (AXI_BVALID !== 1'b1 && n < 40);
		if (AXI_BVALID !== 1'b1) hang("write response");
		AXI_BREADY <= 1'b0;
		check("write response", {30'h0, er}, {30'h0, AXI_BRESP});
	endtask

	task automatic axi_read(input logic [11:0] a, input logic [31:0] exp, input logic [1:0] er);
		int n;
		@(posedge SYS_CLK);
		n = 0;
		AXI_ARADDR  <= {20'h00000, a};
		AXI_ARVALID <= 1'b1;
		AXI_RREADY  <= 1'b1;
		do begin
			@(posedge SYS_CLK);
			n++;
			if (AXI_ARVALID === 1'b1 && AXI_ARREADY === 1'b1) AXI_ARVALID <= 1'b0;
		end while (AXI_RVALID !== 1'b1 && n < 40);
		if (AXI_RVALID !== 1'b1) hang("read data");
		AXI_RREADY <= 1'b0;
		check("read data", exp, AXI_RDATA);
		check("read response", {30'h0, er}, {30'h0, AXI_RRESP});
	endtask

	task automatic check_en(input logic [6:0] exp);
		repeat (2) @(posedge SYS_CLK);
		check("unit clock enables", {25'h0, exp}, {25'h0, UNIT_CLK_EN});
	endtask

	// Counts the edges each unit model receives over ten system clock cycles.
	task automatic check_ticks(input logic [6:0] en);
		@(posedge SYS_CLK);
		clr <= 1'b1;
		@(posedge SYS_CLK);
		clr <= 1'b0;
		repeat (10) @(posedge SYS_CLK);
		#1;
		for (int i = 0; i < 7; i++) check("unit clock edges", en[i] ? 32'hA : 32'h0, ticks[i]);
	endtask

	// ****************************************************************
	// Main sequence
	// ****************************************************************
	initial begin
		SYS_CLK = 0; RESET_N = 0; clr = 1; POWER_MODE = 2'h0; UNIT_SEL = 7'h00;
		AXI_AWVALID = 0; AXI_WVALID = 0; AXI_BREADY = 0; AXI_ARVALID = 0; AXI_RREADY = 0;
		AXI_AWADDR = 32'h0; AXI_WDATA = 32'h0; AXI_ARADDR = 32'h0;
		n_mismatch = 0; num_checks = 0;
		gate_ofs = '{`CG_OFS_RUN_GATE, `CG_OFS_SLEEP_GATE, `CG_OFS_DEEP_GATE};
		bit_pos = '{0, 4, 8, 16, 17, 18, 19};
		mode_gate = '{32'h00000001, 32'h00000010, 32'h00000100, 32'h00000001};
		mode_en = '{7'h01, 7'h02, 7'h04, 7'h01};
		repeat (5) @(posedge SYS_CLK);
		RESET_N <= 1'b1;
		clr <= 1'b0;

		check("enables after reset", 32'h0, {25'h0, UNIT_CLK_EN});
		axi_read(`CG_OFS_RUN_GATE, 32'h00000000, `CG_RESP_OKAY);
		axi_read(`CG_OFS_SLEEP_GATE, 32'h00000000, `CG_RESP_OKAY);
		axi_read(`CG_OFS_DEEP_GATE, 32'h00000000, `CG_RESP_OKAY);
		axi_read(`CG_OFS_RUN_CONFIG, 32'h00000000, `CG_RESP_OKAY);
		axi_read(12'h300, 32'h00000000, `CG_RESP_SLVERR);
		check_ticks(7'h00);
		$display("test reset done");

		foreach (gate_ofs[i]) begin
			axi_write(gate_ofs[i], 32'hFFFFFFFF, `CG_RESP_OKAY);
			axi_read(gate_ofs[i], 32'h000F0111, `CG_RESP_OKAY);
		end
		check_en(7'h7F);
		check_ticks(7'h7F);
		axi_write(`CG_OFS_ACTIVE_GATE, 32'h00000000, `CG_RESP_OKAY);
		axi_read(`CG_OFS_ACTIVE_GATE, 32'h000F0111, `CG_RESP_OKAY);
		axi_write(12'h300, 32'hFFFFFFFF, `CG_RESP_SLVERR);
		$display("test register access done");

		// Software sets each unit's gate bit alone in the run register and checks its enable.
		foreach (bit_pos[i]) begin
			axi_write(`CG_OFS_RUN_GATE, 32'h00000001 << bit_pos[i], `CG_RESP_OKAY);
			check_en(7'h01 << i);
		end
		$display("test bit mapping done");

		axi_write(`CG_OFS_RUN_GATE, 32'h00000001, `CG_RESP_OKAY);
		check_en(7'h01);
		@(posedge SYS_CLK);
		UNIT_SEL <= 7'h7F;
		@(posedge SYS_CLK);
		check("access faults", 32'h7E, {25'h0, UNIT_BUS_FAULT});
		UNIT_SEL <= 7'h01;
		@(posedge SYS_CLK);
		check("clocked unit access", 32'h0, {25'h0, UNIT_BUS_FAULT});
		UNIT_SEL <= 7'h00;
		axi_read(`CG_OFS_IRQ_STATUS, 32'h00000001, `CG_RESP_OKAY);
		check("masked interrupt", 32'h0, {31'h0, IRQ});
		axi_write(`CG_OFS_IRQ_MASK, 32'h00000001, `CG_RESP_OKAY);
		check("unmasked interrupt", 32'h1, {31'h0, IRQ});
		axi_write(`CG_OFS_IRQ_STATUS, 32'h00000001, `CG_RESP_OKAY);
		check("cleared interrupt", 32'h0, {31'h0, IRQ});
		$display("test access fault done");

		axi_write(`CG_OFS_SLEEP_GATE, 32'h00000010, `CG_RESP_OKAY);
		axi_write(`CG_OFS_DEEP_GATE, 32'h00000100, `CG_RESP_OKAY);
		for (int m = 0; m < 4; m++) begin
			@(posedge SYS_CLK);
			POWER_MODE <= m[1:0];
			check_en(7'h01);
		end
		axi_write(`CG_OFS_RUN_CONFIG, 32'h08000000, `CG_RESP_OKAY);
		axi_read(`CG_OFS_RUN_CONFIG, 32'h08000000, `CG_RESP_OKAY);
		for (int m = 0; m < 4; m++) begin
			@(posedge SYS_CLK);
			POWER_MODE <= m[1:0];
			check_en(mode_en[m]);
			axi_read(`CG_OFS_ACTIVE_GATE, mode_gate[m], `CG_RESP_OKAY);
			check_ticks(mode_en[m]);
		end
		axi_read(`CG_OFS_IRQ_STATUS, 32'h00000002, `CG_RESP_OKAY);
		check("masked mode interrupt", 32'h0, {31'h0, IRQ});
		$display("test power modes done");

		@(posedge SYS_CLK);
		RESET_N <= 1'b0;
		repeat (2) @(posedge SYS_CLK);
		RESET_N <= 1'b1;
		check("enables in reset", 32'h0, {25'h0, UNIT_CLK_EN});
		axi_read(`CG_OFS_DEEP_GATE, 32'h00000000, `CG_RESP_OKAY);
		axi_read(`CG_OFS_RUN_CONFIG, 32'h00000000, `CG_RESP_OKAY);
		$display("test second reset done");
		end_sim();
	end
endmodule
